// >>> sxp_packer.sv
// Fabric-side packer driving the four operand buses of a shared-exponent MAC
//
// What this block does
// - Int7 four products: low buses, set 09/09
// - Int7 eight: high buses mirror low, 09/29
// - Int7 nine: eight low, ninth at 62:56
// - Int7 sixteen: all buses, exponents at 63:56
// - Int6 four: a at 23:0, b 55:32
// - Int6 five: b exponent from separate input
// - Int6 eight: high buses mirror low, 0D/2D
// - Int6 ten split: a8-a12, b8-b12 high, 0E/2E
// - Split ten: both b exponents share one input
// - Int6 ten: a8/b8 53:48, a9/b9 59:54
// - Int6 sixteen: 47:0 each bus, exponents 63:56
// - Mantissas signed magnitude, one exponent per group
//
// Our own choices: the Wishbone interface to the registers and the address map.
`timescale 1ns/100ps
module sxp_packer import sxp_pkg::*; (
	input  wire logic             clk_i,          // 10 MHz clock
	input  wire logic             rst_i,          // Synchronous reset
	input  wire logic             ce_i,           // Clock enable
	input  wire logic             wb_cyc_i,       // Bus cycle
	input  wire logic             wb_stb_i,       // Strobe
	input  wire logic             wb_we_i,        // Write enable
	input  wire logic [ADR_W-1:0] wb_adr_i,       // Byte address
	input  wire logic [SEL_W-1:0] wb_sel_i,       // Byte lanes
	input  wire logic [DAT_W-1:0] wb_dat_i,       // Write data
	output logic      [DAT_W-1:0] wb_dat_o,       // Read data
	output logic                  wb_ack_o,       // Acknowledge
	output logic      [BUS_W-1:0] mult_a_lo_o,    // A low bus
	output logic      [BUS_W-1:0] mult_b_lo_o,    // B low bus
	output logic      [BUS_W-1:0] mult_a_hi_o,    // A high bus
	output logic      [BUS_W-1:0] mult_b_hi_o,    // B high bus
	output logic      [EXP_W-1:0] expb_o,         // Separate exponent
	output logic      [LO_W-1:0]  lane_sel_lo_o,  // Low lane select
	output logic      [HI_W-1:0]  lane_sel_hi_o,  // High lane select
	output logic                  exp_5bit_o      // Short exponent flag
);
	logic [MODE_W-1:0] mode;
	logic              exp5;
	logic [EXP_W-1:0]  exp_val [4];
	logic [MANT_W-1:0] mant_a [LANES];
	logic [MANT_W-1:0] mant_b [LANES];
	logic [DAT_W-1:0]  status;
	sxp_layout_t       lay;
	logic [MANT_W-1:0] mask;

	logic [BUS_W-1:0]  a_lo, next_a_lo;
	logic [BUS_W-1:0]  b_lo, next_b_lo;
	logic [BUS_W-1:0]  a_hi, next_a_hi;
	logic [BUS_W-1:0]  b_hi, next_b_hi;
	logic [EXP_W-1:0]  expb, next_expb;
	logic [LO_W-1:0]   sel_lo, next_sel_lo;
	logic [HI_W-1:0]   sel_hi, next_sel_hi;
	logic              short_exp, next_short_exp;
	logic              conflict, next_conflict;

	// Software-facing registers
	sxp_regs u_regs (
		.clk_i    (clk_i),
		.rst_i    (rst_i),
		.ce_i     (ce_i),
		.wb_cyc_i (wb_cyc_i),
		.wb_stb_i (wb_stb_i),
		.wb_we_i  (wb_we_i),
		.wb_adr_i (wb_adr_i),
		.wb_sel_i (wb_sel_i),
		.wb_dat_i (wb_dat_i),
		.wb_dat_o (wb_dat_o),
		.wb_ack_o (wb_ack_o),
		.status_i (status),
		.mode_o   (mode),
		.exp5_o   (exp5),
		.exp_o    (exp_val),
		.mant_a_o (mant_a),
		.mant_b_o (mant_b)
	);

	// Mode table lookup; width picks the mantissa mask
	assign lay  = sxp_layout(mode);
	assign mask = MANT_MASK >> (3'(MANT_W) - lay.wid);

	// Status word: what the buses currently carry
	always_comb begin
		status                           = '0;
		status[ST_VALID]                 = (sel_lo != '0);
		status[ST_CONFL]                 = conflict;
		status[ST_SEL_LO +: LO_W]        = sel_lo;
		status[ST_SEL_HI +: HI_W]        = sel_hi;
	end

	// Bus packing; every bit not named by the mode is driven zero
	always_comb begin
		next_a_lo      = '0;
		next_b_lo      = '0;
		next_a_hi      = '0;
		next_b_hi      = '0;
		next_expb      = '0;
		next_sel_lo    = lay.sel_lo;
		next_sel_hi    = lay.sel_hi;
		next_short_exp = exp5;
		next_conflict  = lay.exd_sep && (exp_val[1] != exp_val[3]);
		// Mantissas pass as written; sign sits in the field's top bit
		for (int i = 0; i < HALF; i++) begin
			if (4'(i) < lay.n_lo) begin
				next_a_lo |= BUS_W'(mant_a[i] & mask) << (lay.a_lo + lay.wid * i);
				next_b_lo |= BUS_W'(mant_b[i] & mask) << (lay.b_lo + lay.wid * i);
			end
			if (4'(i) < lay.n_hi) begin
				next_a_hi |= BUS_W'(mant_a[HALF+i] & mask) << (lay.a_hi + lay.wid * i);
				next_b_hi |= BUS_W'(mant_b[HALF+i] & mask) << (lay.b_hi + lay.wid * i);
			end
		end
		// Low half exponents, b optionally on the separate input
		if (lay.n_lo != '0) begin
			next_a_lo |= BUS_W'(exp_val[0]) << lay.exa;
			if (lay.exb_sep) begin
				next_expb = exp_val[1];
			end else begin
				next_b_lo |= BUS_W'(exp_val[1]) << lay.exb;
			end
		end
		// High half exponents; split mode reuses the low b exponent
		if (lay.n_hi != '0) begin
			next_a_hi |= BUS_W'(exp_val[2]) << lay.exc;
			if (!lay.exd_sep) begin
				next_b_hi |= BUS_W'(exp_val[3]) << lay.exd;
			end
		end
	end

	// Output stage; data and selects change together so no mixed frame
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			a_lo      <= '0;
			b_lo      <= '0;
			a_hi      <= '0;
			b_hi      <= '0;
			expb      <= '0;
			sel_lo    <= '0;
			sel_hi    <= '0;
			short_exp <= 1'b0;
			conflict  <= 1'b0;
		end else if (ce_i) begin
			a_lo      <= next_a_lo;
			b_lo      <= next_b_lo;
			a_hi      <= next_a_hi;
			b_hi      <= next_b_hi;
			expb      <= next_expb;
			sel_lo    <= next_sel_lo;
			sel_hi    <= next_sel_hi;
			short_exp <= next_short_exp;
			conflict  <= next_conflict;
		end
	end

	assign mult_a_lo_o   = a_lo;
	assign mult_b_lo_o   = b_lo;
	assign mult_a_hi_o   = a_hi;
	assign mult_b_hi_o   = b_hi;
	assign expb_o        = expb;
	assign lane_sel_lo_o = sel_lo;
	assign lane_sel_hi_o = sel_hi;
	assign exp_5bit_o    = short_exp;

	// Checks: layout and flag checks tied to the registers one enabled edge earlier; freeze and ack checks are not
	int7_x1_a: assert property (@(posedge clk_i) disable iff (rst_i)
		$past(ce_i) && sel_lo == 5'h09 && sel_hi == 6'h09 |->
		a_hi == '0 && b_hi == '0 && a_lo[63:56] == $past(exp_val[0])
		&& b_lo[71:64] == $past(exp_val[1]) && b_lo[34:28] == $past(mant_b[0]))
		else $error("int7 four-product layout wrong");

	int7_split_a: assert property (@(posedge clk_i) disable iff (rst_i)
		$past(ce_i) && sel_hi == 6'h29 |->
		a_hi[6:0] == $past(mant_a[8]) && a_hi[63:56] == $past(exp_val[2])
		&& b_hi[71:64] == $past(exp_val[3]) && b_hi[55:49] == $past(mant_b[11]))
		else $error("int7 split high bus wrong");

	int7_nine_a: assert property (@(posedge clk_i) disable iff (rst_i)
		$past(ce_i) && sel_lo == 5'h1B |->
		a_hi[62:56] == $past(mant_a[8]) && b_hi[62:56] == $past(mant_b[8])
		&& a_hi[55:0] == '0 && a_lo[55:49] == $past(mant_a[7])
		&& b_hi[71:64] == $past(exp_val[3]))
		else $error("int7 nine-product layout wrong");

	int7_x4_a: assert property (@(posedge clk_i) disable iff (rst_i)
		$past(ce_i) && sel_lo == 5'h1C |->
		a_hi[55:49] == $past(mant_a[15]) && b_lo[63:56] == $past(exp_val[1])
		&& b_hi[63:56] == $past(exp_val[3]) && a_lo[71:64] == '0)
		else $error("int7 sixteen-product layout wrong");

	int6_four_a: assert property (@(posedge clk_i) disable iff (rst_i)
		$past(ce_i) && sel_lo == 5'h0D && sel_hi == 6'h0D |->
		a_lo[31:24] == $past(exp_val[0]) && b_lo[37:32] == $past(mant_b[0][5:0])
		&& b_lo[63:56] == $past(exp_val[1]) && a_hi == '0 && a_lo[71:32] == '0)
		else $error("int6 four-product layout wrong");

	int6_sep_a: assert property (@(posedge clk_i) disable iff (rst_i)
		$past(ce_i) && sel_lo == 5'h0E |->
		a_lo[71:64] == $past(exp_val[0]) && expb == $past(exp_val[1])
		&& b_lo[59:54] == $past(mant_b[4][5:0]) && b_lo[71:60] == '0)
		else $error("int6 separate exponent layout wrong");

	int6_mirror_a: assert property (@(posedge clk_i) disable iff (rst_i)
		$past(ce_i) && sel_hi == 6'h2D |->
		a_hi[31:24] == $past(exp_val[2]) && b_hi[63:56] == $past(exp_val[3])
		&& a_hi[23:18] == $past(mant_a[11][5:0]))
		else $error("int6 mirrored high bus wrong");

	int6_split_a: assert property (@(posedge clk_i) disable iff (rst_i)
		$past(ce_i) && sel_hi == 6'h2E |->
		a_hi[71:64] == $past(exp_val[2]) && b_hi[59:54] == $past(mant_b[12][5:0])
		&& a_hi[29:24] == $past(mant_a[12][5:0]) && b_hi[71:60] == '0)
		else $error("int6 split high bus wrong");

	expb_common_a: assert property (@(posedge clk_i) disable iff (rst_i)
		$past(ce_i) && sel_hi == 6'h2E |->
		expb == $past(exp_val[1])
		&& conflict == ($past(exp_val[1]) != $past(exp_val[3])))
		else $error("shared exponent input wrong");

	int6_ten_a: assert property (@(posedge clk_i) disable iff (rst_i)
		$past(ce_i) && sel_lo == 5'h0F |->
		a_hi[53:48] == $past(mant_a[8][5:0]) && a_hi[59:54] == $past(mant_a[9][5:0])
		&& b_hi[47:0] == '0 && b_hi[71:64] == $past(exp_val[3]))
		else $error("int6 ten-product layout wrong");

	int6_x4_a: assert property (@(posedge clk_i) disable iff (rst_i)
		$past(ce_i) && sel_lo == 5'h10 |->
		a_hi[47:42] == $past(mant_a[15][5:0]) && a_lo[55:48] == '0
		&& a_lo[63:56] == $past(exp_val[0]))
		else $error("int6 sixteen-product layout wrong");

	short_exp_a: assert property (@(posedge clk_i) disable iff (rst_i)
		$past(ce_i) |-> short_exp == $past(exp5))
		else $error("short exponent flag lags");

	freeze_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!ce_i [*2] |=> $stable(a_lo) && $stable(b_hi) && $stable(sel_lo))
		else $error("outputs moved while enable low");

	ack_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
		wb_ack_o && ce_i |=> !wb_ack_o)
		else $error("ack held past one cycle");

	// Main scenarios
	int7_split_c: cover property (@(posedge clk_i) disable iff (rst_i)
		sel_lo == 5'h09 && sel_hi == 6'h29);
	int6_split_c: cover property (@(posedge clk_i) disable iff (rst_i)
		sel_hi == 6'h2E && conflict);
	int6_ten_c: cover property (@(posedge clk_i) disable iff (rst_i)
		sel_lo == 5'h0F);
	mode_swap_c: cover property (@(posedge clk_i) disable iff (rst_i)
		sel_lo == 5'h1C ##1 sel_lo == 5'h10);
endmodule : sxp_packer

// >>> sxp_pkg.sv
// Constants, register map and lane layouts for the shared-exponent operand packer
package sxp_pkg;
	// Bus and field widths
	localparam int BUS_W  = 72;
	localparam int EXP_W  = 8;
	localparam int MANT_W = 7;
	localparam int LANES  = 16;
	localparam int HALF   = 8;
	localparam int ADR_W  = 8;
	localparam int DAT_W  = 32;
	localparam int SEL_W  = 4;
	localparam int MODE_W = 4;
	localparam int LO_W   = 5;
	localparam int HI_W   = 6;

	// Register map: region in address bits [7:6], word index in [5:2]
	localparam logic [1:0] REG_CTL    = 2'h0;
	localparam logic [1:0] REG_MANT_A = 2'h1;
	localparam logic [1:0] REG_MANT_B = 2'h2;
	localparam logic [3:0] IDX_CTRL   = 4'h0;
	localparam logic [3:0] IDX_STATUS = 4'h1;
	localparam logic [3:0] IDX_EXP_LO = 4'h2;
	localparam logic [3:0] IDX_EXP_HI = 4'h5;

	// Control and status fields
	localparam int CTRL_EXP5  = 4;
	localparam int ST_VALID   = 0;
	localparam int ST_CONFL   = 1;
	localparam int ST_SEL_LO  = 8;
	localparam int ST_SEL_HI  = 16;

	// Packing modes as written to the control register
	localparam logic [3:0] M_I7_X1    = 4'h0;
	localparam logic [3:0] M_I7_SPLIT = 4'h1;
	localparam logic [3:0] M_I7_NINE  = 4'h2;
	localparam logic [3:0] M_I7_X4    = 4'h3;
	localparam logic [3:0] M_I6_X1    = 4'h4;
	localparam logic [3:0] M_I6_SEP   = 4'h5;
	localparam logic [3:0] M_I6_MIR   = 4'h6;
	localparam logic [3:0] M_I6_SPLIT = 4'h7;
	localparam logic [3:0] M_I6_TEN   = 4'h8;
	localparam logic [3:0] M_I6_X4    = 4'h9;

	localparam logic [6:0] MANT_MASK  = 7'h7F;

	// Where each field of one mode sits on the four buses
	typedef struct packed {
		logic [4:0] sel_lo;
		logic [5:0] sel_hi;
		logic [2:0] wid;
		logic [3:0] n_lo;
		logic [6:0] a_lo;
		logic [6:0] b_lo;
		logic [6:0] exa;
		logic [6:0] exb;
		logic [3:0] n_hi;
		logic [6:0] a_hi;
		logic [6:0] b_hi;
		logic [6:0] exc;
		logic [6:0] exd;
		logic       exb_sep;
		logic       exd_sep;
	} sxp_layout_t;

	// Layout per mode; unknown modes give all zero, so no bus field or lane select is driven
	function automatic sxp_layout_t sxp_layout(input logic [3:0] mode);
		sxp_layout_t l;
		l = '0;
		case (mode)
			M_I7_X1:    l = '{5'h09, 6'h09, 3'h7, 4'h4, 7'h00, 7'h1C, 7'h38, 7'h40,
				4'h0, 7'h00, 7'h00, 7'h00, 7'h00, 1'b0, 1'b0};
			M_I7_SPLIT: l = '{5'h09, 6'h29, 3'h7, 4'h4, 7'h00, 7'h1C, 7'h38, 7'h40,
				4'h4, 7'h00, 7'h1C, 7'h38, 7'h40, 1'b0, 1'b0};
			M_I7_NINE:  l = '{5'h1B, 6'h1B, 3'h7, 4'h8, 7'h00, 7'h00, 7'h40, 7'h40,
				4'h1, 7'h38, 7'h38, 7'h40, 7'h40, 1'b0, 1'b0};
			M_I7_X4:    l = '{5'h1C, 6'h1C, 3'h7, 4'h8, 7'h00, 7'h00, 7'h38, 7'h38,
				4'h8, 7'h00, 7'h00, 7'h38, 7'h38, 1'b0, 1'b0};
			M_I6_X1:    l = '{5'h0D, 6'h0D, 3'h6, 4'h4, 7'h00, 7'h20, 7'h18, 7'h38,
				4'h0, 7'h00, 7'h00, 7'h00, 7'h00, 1'b0, 1'b0};
			M_I6_SEP:   l = '{5'h0E, 6'h0E, 3'h6, 4'h5, 7'h00, 7'h1E, 7'h40, 7'h00,
				4'h0, 7'h00, 7'h00, 7'h00, 7'h00, 1'b1, 1'b0};
			M_I6_MIR:   l = '{5'h0D, 6'h2D, 3'h6, 4'h4, 7'h00, 7'h20, 7'h18, 7'h38,
				4'h4, 7'h00, 7'h20, 7'h18, 7'h38, 1'b0, 1'b0};
			M_I6_SPLIT: l = '{5'h0E, 6'h2E, 3'h6, 4'h5, 7'h00, 7'h1E, 7'h40, 7'h00,
				4'h5, 7'h00, 7'h1E, 7'h40, 7'h00, 1'b1, 1'b1};
			M_I6_TEN:   l = '{5'h0F, 6'h0F, 3'h6, 4'h8, 7'h00, 7'h00, 7'h40, 7'h40,
				4'h2, 7'h30, 7'h30, 7'h40, 7'h40, 1'b0, 1'b0};
			M_I6_X4:    l = '{5'h10, 6'h10, 3'h6, 4'h8, 7'h00, 7'h00, 7'h38, 7'h38,
				4'h8, 7'h00, 7'h00, 7'h38, 7'h38, 1'b0, 1'b0};
			default:    l = '0;
		endcase
		return l;
	endfunction : sxp_layout
endpackage : sxp_pkg

// >>> sxp_regs.sv
// Wishbone register bank holding mode, exponents and mantissas
`timescale 1ns/100ps
module sxp_regs import sxp_pkg::*; (
	input  wire logic              clk_i,                // System clock
	input  wire logic              rst_i,                // Synchronous reset
	input  wire logic              ce_i,                 // Clock enable
	input  wire logic              wb_cyc_i,             // Bus cycle
	input  wire logic              wb_stb_i,             // Strobe
	input  wire logic              wb_we_i,              // Write enable
	input  wire logic [ADR_W-1:0]  wb_adr_i,             // Byte address
	input  wire logic [SEL_W-1:0]  wb_sel_i,             // Byte lanes
	input  wire logic [DAT_W-1:0]  wb_dat_i,             // Write data
	output logic      [DAT_W-1:0]  wb_dat_o,             // Read data
	output logic                   wb_ack_o,             // Acknowledge
	input  wire logic [DAT_W-1:0]  status_i,             // Status word
	output logic      [MODE_W-1:0] mode_o,               // Packing mode
	output logic                   exp5_o,               // Short exponent
	output logic      [EXP_W-1:0]  exp_o [4],            // Exponents a..d
	output logic      [MANT_W-1:0] mant_a_o [LANES],     // A mantissas
	output logic      [MANT_W-1:0] mant_b_o [LANES]      // B mantissas
);
	logic [MODE_W-1:0] mode, next_mode;
	logic              exp5, next_exp5;
	logic [EXP_W-1:0]  exp_val [4];
	logic [EXP_W-1:0]  next_exp_val [4];
	logic [MANT_W-1:0] mant_a [LANES];
	logic [MANT_W-1:0] next_mant_a [LANES];
	logic [MANT_W-1:0] mant_b [LANES];
	logic [MANT_W-1:0] next_mant_b [LANES];
	logic              ack, next_ack;
	logic [DAT_W-1:0]  rdat, next_rdat;
	logic              req;
	logic [1:0]        region;
	logic [3:0]        idx;
	logic [1:0]        eidx;

	assign req    = wb_cyc_i & wb_stb_i & ~ack;
	assign region = wb_adr_i[7:6];
	assign idx    = wb_adr_i[5:2];
	assign eidx   = 2'(idx - IDX_EXP_LO);

	// Decode; one ack per request, unmapped reads give zero, writes dropped
	always_comb begin
		next_mode    = mode;
		next_exp5    = exp5;
		next_exp_val = exp_val;
		next_mant_a  = mant_a;
		next_mant_b  = mant_b;
		next_ack     = req;
		next_rdat    = '0;
		if (req && wb_we_i && wb_sel_i[0]) begin
			case (region)
				REG_CTL: begin
					if (idx == IDX_CTRL) begin
						next_mode = wb_dat_i[MODE_W-1:0];
						next_exp5 = wb_dat_i[CTRL_EXP5];
					end else if (idx >= IDX_EXP_LO && idx <= IDX_EXP_HI) begin
						next_exp_val[eidx] = wb_dat_i[EXP_W-1:0];
					end
				end
				REG_MANT_A: next_mant_a[idx] = wb_dat_i[MANT_W-1:0];
				REG_MANT_B: next_mant_b[idx] = wb_dat_i[MANT_W-1:0];
				default: ;
			endcase
		end else if (req) begin
			case (region)
				REG_CTL: begin
					if (idx == IDX_CTRL) begin
						next_rdat[MODE_W-1:0] = mode;
						next_rdat[CTRL_EXP5]  = exp5;
					end else if (idx == IDX_STATUS) begin
						next_rdat = status_i;
					end else if (idx >= IDX_EXP_LO && idx <= IDX_EXP_HI) begin
						next_rdat[EXP_W-1:0] = exp_val[eidx];
					end
				end
				REG_MANT_A: next_rdat[MANT_W-1:0] = mant_a[idx];
				REG_MANT_B: next_rdat[MANT_W-1:0] = mant_b[idx];
				default: ;
			endcase
		end
	end

	// Register stage, frozen while the enable is low
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mode    <= '0;
			exp5    <= 1'b0;
			exp_val <= '{default: '0};
			mant_a  <= '{default: '0};
			mant_b  <= '{default: '0};
			ack     <= 1'b0;
			rdat    <= '0;
		end else if (ce_i) begin
			mode    <= next_mode;
			exp5    <= next_exp5;
			exp_val <= next_exp_val;
			mant_a  <= next_mant_a;
			mant_b  <= next_mant_b;
			ack     <= next_ack;
			rdat    <= next_rdat;
		end
	end

	assign wb_ack_o = ack;
	assign wb_dat_o = rdat;
	assign mode_o   = mode;
	assign exp5_o   = exp5;
	assign exp_o    = exp_val;
	assign mant_a_o = mant_a;
	assign mant_b_o = mant_b;
endmodule : sxp_regs

// >>> sxp_vpkg.sv
// Lane layouts and sign-magnitude helper shared by the bench and the device model
package sxp_vpkg;
	// Field offsets for one lane-select pair; -1 marks the separate exponent input
	typedef struct {
		int w, nl, al, bl, exa, exb, nh, ah, bh, exc, exd;
	} sxp_vlay_t;

	// Layout per lane-select pair; unknown pairs give width 0, so no products
	function automatic sxp_vlay_t sxp_vlay(input logic [4:0] lo, input logic [5:0] hi);
		sxp_vlay_t l;
		l = '{default: 0};
		case ({lo, hi})
			{5'h09, 6'h09}: l = '{7, 4, 0, 28, 56, 64, 0, 0, 0, 0, 0};
			{5'h09, 6'h29}: l = '{7, 4, 0, 28, 56, 64, 4, 0, 28, 56, 64};
			{5'h1B, 6'h1B}: l = '{7, 8, 0, 0, 64, 64, 1, 56, 56, 64, 64};
			{5'h1C, 6'h1C}: l = '{7, 8, 0, 0, 56, 56, 8, 0, 0, 56, 56};
			{5'h0D, 6'h0D}: l = '{6, 4, 0, 32, 24, 56, 0, 0, 0, 0, 0};
			{5'h0E, 6'h0E}: l = '{6, 5, 0, 30, 64, -1, 0, 0, 0, 0, 0};
			{5'h0D, 6'h2D}: l = '{6, 4, 0, 32, 24, 56, 4, 0, 32, 24, 56};
			{5'h0E, 6'h2E}: l = '{6, 5, 0, 30, 64, -1, 5, 0, 30, 64, -1};
			{5'h0F, 6'h0F}: l = '{6, 8, 0, 0, 64, 64, 2, 48, 48, 64, 64};
			{5'h10, 6'h10}: l = '{6, 8, 0, 0, 56, 56, 8, 0, 0, 56, 56};
			default:        l = '{default: 0};
		endcase
		return l;
	endfunction : sxp_vlay

	// Signed-magnitude value of the low w bits; higher bits never reach the product
	function automatic int sxp_sm(input logic [71:0] v, input int w);
		int mag;
		mag = int'(v & ((72'h1 << (w - 1)) - 72'h1));
		return v[w - 1] ? -mag : mag;
	endfunction : sxp_sm
endpackage : sxp_vpkg

// >>> sxp_mac_model.sv
// Behavioural multiply-accumulate device fed by the operand buses
`timescale 1ns/100ps
module sxp_mac_model import sxp_vpkg::*; (
	input  wire logic [71:0] mult_a_lo_i,   // A low bus
	input  wire logic [71:0] mult_b_lo_i,   // B low bus
	input  wire logic [71:0] mult_a_hi_i,   // A high bus
	input  wire logic [71:0] mult_b_hi_i,   // B high bus
	input  wire logic [7:0]  expb_i,        // Separate exponent
	input  wire logic [4:0]  lane_sel_lo_i, // Low lane select
	input  wire logic [5:0]  lane_sel_hi_i, // High lane select
	input  wire logic        exp_5bit_i,    // Short exponent
	output int               sum_ab_o,      // Low-half dot product
	output int               sum_cd_o,      // High-half dot product
	output int               exp_ab_o,      // Low-half scale exponent
	output int               exp_cd_o       // High-half scale exponent
);
	sxp_vlay_t lay;

	// Exponent from its bus field or the separate input, cut to 5 bits on request
	function automatic int pick(input logic [71:0] bus, input int pos, input logic [7:0] sep,
		input logic short);
		logic [7:0] e;
		e = sep;
		if (pos >= 0)
			e = bus[pos +: 8];
		return short ? int'(e[4:0]) : int'(e);
	endfunction : pick

	// Only fields of the decoded layout are read; every other bus bit is ignored
	always_comb begin
		lay = sxp_vlay(lane_sel_lo_i, lane_sel_hi_i);
		sum_ab_o = 0;
		sum_cd_o = 0;
		for (int i = 0; i < lay.nl; i++)
			sum_ab_o += sxp_sm(mult_a_lo_i >> (lay.al + lay.w * i), lay.w)
				* sxp_sm(mult_b_lo_i >> (lay.bl + lay.w * i), lay.w);
		for (int i = 0; i < lay.nh; i++)
			sum_cd_o += sxp_sm(mult_a_hi_i >> (lay.ah + lay.w * i), lay.w)
				* sxp_sm(mult_b_hi_i >> (lay.bh + lay.w * i), lay.w);
		// Scaling kept as the sum of the two exponents of each half
		exp_ab_o = 0;
		exp_cd_o = 0;
		if (lay.nl > 0)
			exp_ab_o = pick(mult_a_lo_i, lay.exa, expb_i, exp_5bit_i)
				+ pick(mult_b_lo_i, lay.exb, expb_i, exp_5bit_i);
		if (lay.nh > 0)
			exp_cd_o = pick(mult_a_hi_i, lay.exc, expb_i, exp_5bit_i)
				+ pick(mult_b_hi_i, lay.exd, expb_i, exp_5bit_i);
	end
endmodule : sxp_mac_model

// >>> tb_sxp_packer.sv
// Self-checking bench for the shared-exponent operand packer
`timescale 1ns/100ps
module tb_sxp_packer import sxp_pkg::*, sxp_vpkg::*; ;
	logic        clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1;
	logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
	logic [7:0]  wb_adr_i = 8'h00;
	logic [3:0]  wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rq;
	logic        wb_ack_o, exp_5bit_o;
	logic [71:0] bus_o [4];
	logic [7:0]  expb_o;
	logic [4:0]  lane_sel_lo_o;
	logic [5:0]  lane_sel_hi_o;
	int          sum_ab, sum_cd, exp_ab, exp_cd;
	logic [6:0]  ma [16], mb [16];
	logic [7:0]  ex [4];
	int          miscompares = 0, checks_done = 0;

	sxp_packer i_sxp_packer (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.mult_a_lo_o(bus_o[0]), .mult_b_lo_o(bus_o[1]), .mult_a_hi_o(bus_o[2]),
		.mult_b_hi_o(bus_o[3]), .expb_o(expb_o), .lane_sel_lo_o(lane_sel_lo_o),
		.lane_sel_hi_o(lane_sel_hi_o), .exp_5bit_o(exp_5bit_o));

	sxp_mac_model i_sxp_mac_model (.mult_a_lo_i(bus_o[0]), .mult_b_lo_i(bus_o[1]),
		.mult_a_hi_i(bus_o[2]), .mult_b_hi_i(bus_o[3]), .expb_i(expb_o),
		.lane_sel_lo_i(lane_sel_lo_o), .lane_sel_hi_i(lane_sel_hi_o),
		.exp_5bit_i(exp_5bit_o), .sum_ab_o(sum_ab), .sum_cd_o(sum_cd),
		.exp_ab_o(exp_ab), .exp_cd_o(exp_cd));

	// 10 MHz clock
	always #50 clk_i = ~clk_i;

	task automatic chk(input string nm, input logic [71:0] e, input logic [71:0] g);
		checks_done++;
		if (g !== e) begin
			$display("unexpected %s: expected %h seen %h", nm, e, g);
			miscompares++;
		end
	endtask : chk

	// Classic cycle; request held until ack is seen at a rising edge, no fixed latency
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s, output logic [31:0] q);
		int n;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_sel_i <= s;
		wb_dat_i <= d;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 50);
		chk("bus ack", 72'h1, 72'(wb_ack_o));
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask : wb

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		logic [31:0] q;
		wb(1'b1, a, d, s, q);
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] q);
		wb(1'b0, a, 32'h0, 4'hF, q);
	endtask : rd

	task automatic t_reset();
		@(posedge clk_i);
		chk("idle buses", 72'h0, bus_o[0] | bus_o[1] | bus_o[2] | bus_o[3]);
		chk("idle selects", 72'h0, {59'h0, expb_o, lane_sel_lo_o});
		chk("idle hi select", 72'h0, {65'h0, wb_ack_o, lane_sel_hi_o});
		$display("reset test done");
	endtask : t_reset

	task automatic t_load();
		for (int i = 0; i < 16; i++) begin
			wr(8'(8'h40 + 4 * i), {25'h0, ma[i]}, 4'hF);
			wr(8'(8'h80 + 4 * i), {25'h0, mb[i]}, 4'hF);
		end
		for (int k = 0; k < 4; k++)
			wr(8'(8'h08 + 4 * k), {24'h0, ex[k]}, 4'hF);
		$display("load test done");
	endtask : t_load

	// One packing mode: expected buses, model products and status from the layout
	task automatic t_mode(input logic [3:0] m, input logic [4:0] lo, input logic [5:0] hi);
		sxp_vlay_t l;
		logic [71:0] e [4];
		logic [6:0] mk;
		int sab, scd;
		l = sxp_vlay(lo, hi);
		mk = 7'h7F >> (7 - l.w);
		e = '{default: 72'h0};
		sab = 0;
		scd = 0;
		for (int i = 0; i < l.nl; i++) begin
			e[0] |= 72'(ma[i] & mk) << (l.al + l.w * i);
			e[1] |= 72'(mb[i] & mk) << (l.bl + l.w * i);
			sab += sxp_sm(72'(ma[i]), l.w) * sxp_sm(72'(mb[i]), l.w);
		end
		for (int i = 0; i < l.nh; i++) begin
			e[2] |= 72'(ma[8 + i] & mk) << (l.ah + l.w * i);
			e[3] |= 72'(mb[8 + i] & mk) << (l.bh + l.w * i);
			scd += sxp_sm(72'(ma[8 + i]), l.w) * sxp_sm(72'(mb[8 + i]), l.w);
		end
		e[0] |= 72'(ex[0]) << l.exa;
		if (l.exb >= 0)
			e[1] |= 72'(ex[1]) << l.exb;
		if (l.nh > 0)
			e[2] |= 72'(ex[2]) << l.exc;
		if (l.nh > 0 && l.exd >= 0)
			e[3] |= 72'(ex[3]) << l.exd;
		wr(8'h00, {28'h0, m}, 4'hF);
		repeat (2) @(posedge clk_i);
		chk("lane_sel_lo", 72'(lo), 72'(lane_sel_lo_o));
		chk("lane_sel_hi", 72'(hi), 72'(lane_sel_hi_o));
		for (int k = 0; k < 4; k++)
			chk("operand bus", e[k], bus_o[k]);
		chk("expb", (l.exb < 0) ? 72'(ex[1]) : 72'h0, 72'(expb_o));
		chk("sum_ab", 72'(sab), 72'(sum_ab));
		chk("sum_cd", 72'(scd), 72'(sum_cd));
		chk("exp_ab", 72'(int'(ex[0]) + int'(ex[1])), 72'(exp_ab));
		chk("exp_cd", (l.nh > 0) ? 72'(int'(ex[2]) + int'(ex[3])) : 72'h0, 72'(exp_cd));
		rd(8'h04, rq);
		chk("status", {50'h0, hi, 3'h0, lo, 7'h0, 1'b1}, 72'(rq));
		$display("mode %0d test done", m);
	endtask : t_mode

	// Ignored write, undefined mode and unmapped place
	task automatic t_refuse();
		wr(8'h00, 32'h3, 4'hE);
		repeat (2) @(posedge clk_i);
		chk("masked write", 72'h0E, 72'(lane_sel_lo_o));
		wr(8'h00, 32'hA, 4'hF);
		repeat (2) @(posedge clk_i);
		chk("bad mode selects", 72'h0, {61'h0, lane_sel_hi_o, lane_sel_lo_o});
		chk("bad mode buses", 72'h0, bus_o[0] | bus_o[1] | bus_o[2] | bus_o[3]);
		rd(8'h04, rq);
		chk("bad mode status", 72'h0, 72'(rq));
		wr(8'h30, 32'hFFFFFFFF, 4'hF);
		rd(8'h30, rq);
		chk("unmapped read", 72'h0, 72'(rq));
		$display("refusal test done");
	endtask : t_refuse

	task automatic t_exp5();
		wr(8'h00, 32'h10, 4'hF);
		repeat (2) @(posedge clk_i);
		chk("exp_5bit", 72'h1, 72'(exp_5bit_o));
		chk("short exp_ab", 72'(int'(ex[0][4:0]) + int'(ex[1][4:0])), 72'(exp_ab));
		$display("short exponent test done");
	endtask : t_exp5

	// Enable dropped right after a write is taken: ack and low lane select must hold
	task automatic t_freeze();
		fork begin
			repeat (2) @(posedge clk_i);
			ce_i <= 1'b0;
		end join_none
		wr(8'h00, 32'h3, 4'hF);
		repeat (2) @(posedge clk_i);
		chk("frozen ack", 72'h1, 72'(wb_ack_o));
		chk("frozen select", 72'h09, 72'(lane_sel_lo_o));
		ce_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		chk("thawed select", 72'h1C, 72'(lane_sel_lo_o));
		chk("thawed ack", 72'h0, 72'(wb_ack_o));
		$display("enable freeze test done");
	endtask : t_freeze

	task tally_and_finish();
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : tally_and_finish

	// Main sequence; split mode last since it needs equal b and d exponents
	initial begin
		ex = '{8'h91, 8'h3C, 8'h27, 8'hE6};
		for (int i = 0; i < 16; i++) begin
			ma[i] = 7'(i * 13 + 5);
			mb[i] = 7'(i * 29 + 70);
		end
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset();
		t_load();
		t_mode(M_I7_X1, 5'h09, 6'h09);
		t_mode(M_I7_SPLIT, 5'h09, 6'h29);
		t_mode(M_I7_NINE, 5'h1B, 6'h1B);
		t_mode(M_I7_X4, 5'h1C, 6'h1C);
		t_mode(M_I6_X1, 5'h0D, 6'h0D);
		t_mode(M_I6_SEP, 5'h0E, 6'h0E);
		t_mode(M_I6_MIR, 5'h0D, 6'h2D);
		t_mode(M_I6_TEN, 5'h0F, 6'h0F);
		t_mode(M_I6_X4, 5'h10, 6'h10);
		ex[3] = ex[1];
		wr(8'h14, {24'h0, ex[1]}, 4'hF);
		t_mode(M_I6_SPLIT, 5'h0E, 6'h2E);
		// Unequal b and d exponents in split mode must show as a conflict
		wr(8'h14, 32'h5A, 4'hF);
		rd(8'h04, rq);
		chk("conflict", {50'h0, 6'h2E, 3'h0, 5'h0E, 6'h0, 2'h3}, 72'(rq));
		t_refuse();
		t_exp5();
		t_freeze();
		tally_and_finish();
	end

	// Watchdog well beyond the few hundred cycles the tests need
	initial begin
		repeat (5000) @(posedge clk_i);
		miscompares++;
		tally_and_finish();
	end
endmodule : tb_sxp_packer
